// File: core/wdc_defs.svh
// Holds the offsets, field positions, reset values and counts of the decrement interpreter.
// Assumes inclusion by bare name from the package and the design file.
`ifndef WDC_DEFS_SVH
`define WDC_DEFS_SVH
`define WDC_ADDR_WIPER0 4'h0
`define WDC_ADDR_WIPER1 4'h1
`define WDC_ADDR_TCON 4'h4
`define WDC_ADDR_STATUS 4'h5
`define WDC_ADDR_WL0 4'h2
`define WDC_ADDR_WL1 4'h3
`define WDC_ADDR_WP 4'hF
`define WDC_CMD_WRITE 2'h0
`define WDC_CMD_INC 2'h1
`define WDC_CMD_DEC 2'h2
`define WDC_CMD_READ 2'h3
`define WDC_BITS_BYTE 4'h8
`define WDC_BITS_DECODE 4'h6
`define WDC_BIT_ERR 4'h7
`define WDC_FULL_8BIT 9'h100
`define WDC_FULL_7BIT 9'h080
`define WDC_WIPER_RST 9'h080
`define WDC_ZERO 9'h000
`endif

// File: core/wdc_pkg.sv
// Holds the types shared by the decrement interpreter.
// Assumes wdc_defs.svh is on the include path.
`include "wdc_defs.svh"
package wdc_pkg;
  typedef enum logic [1:0] {
    WDC_IDLE = 2'h0,
    WDC_SHIFT = 2'h1,
    WDC_ERROR = 2'h3
  } wdc_state_e;
  typedef struct packed {
    logic wiper0_lock;
    logic wiper1_lock;
    logic write_protect;
  } wdc_prot_s;
endpackage

// File: core/wdc_decrement.sv
// Holds the serial command interpreter for wiper decrement and protection-bit modify.
// Assumes the link pins arrive asynchronously and the nonvolatile writer runs elsewhere.
// What this block does
// - Decrement is one eight-bit command byte only.
// - Decrement accepted on wipers 0 and 1, and on protection bits under high voltage.
// - Update only after full eight-clock command.
// - Accepted decrement lowers wiper by one.
// - Only wiper zero or one is adjusted.
// - Invalid command drives output low until deselect.
// - Error flag appears on output at clock seven.
// - Decrement works from full scale downward.
// - Values above full scale block decrement.
// - Zero scale stays unchanged, no wrap.
// - Repeated decrements allowed in one select period.
// - Any valid command may follow, any wiper.
// - Wiper moves after the eighth clock.
// - High-voltage commands modify lock and protect bits.
// - Protection write starts after command and deselect.
// - During write cycle only volatile addresses accepted.
// - Address and command decoded from first six bits.
`timescale 1ns/1ps
`include "wdc_defs.svh"
module wdc_decrement #(
  parameter bit EIGHT_BIT = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sel_n_i,
  input wire logic high_voltage_select_level_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic nvm_write_active_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic command_error_flag_o,
  output logic [8:0] wiper0_o,
  output logic [8:0] wiper1_o,
  output wdc_pkg::wdc_prot_s prot_o,
  output logic nvm_start_o
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic sck_d_r;
  always_ff @(posedge sys_clk_i) begin
    s1_r <= {high_voltage_select_level_i, sel_n_i, sck_i, sdi_i};
    s2_r <= s1_r;
    sck_d_r <= s2_r[1];
  end
  logic sel_act;
  logic hv;
  logic rise;
  logic fall;
  assign sel_act = ~s2_r[2];
  assign hv = s2_r[3];
  assign rise = s2_r[1] & ~sck_d_r;
  assign fall = ~s2_r[1] & sck_d_r;
  // ************************************************************
  // Command shifter and decode
  // ************************************************************
  wdc_pkg::wdc_state_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic err_r, err_nxt;
  logic [8:0] w0_r, w0_nxt, w1_r, w1_nxt;
  wdc_pkg::wdc_prot_s prot_r, prot_nxt, pend_r, pend_nxt;
  logic pend_v_r, pend_v_nxt, start_r, start_nxt, sdo_r, sdo_nxt, oe_r, oe_nxt;
  logic [8:0] full;
  logic [3:0] addr;
  logic [1:0] cmd;
  logic bad;
  logic [7:0] shin;
  assign full = EIGHT_BIT ? `WDC_FULL_8BIT : `WDC_FULL_7BIT;
  assign shin = {sh_r[6:0], s2_r[0]};
  // Address and command are taken from the first six bits of the byte.
  assign addr = sh_r[5:2];
  assign cmd = sh_r[1:0];
  // By the eighth clock two more bits have entered, so the fields sit two places higher.
  logic [3:0] addr_b;
  logic [1:0] cmd_b;
  assign addr_b = shin[7:4];
  assign cmd_b = shin[3:2];
  always_comb begin
    bad = 1'b0;
    if (nvm_write_active_i && !(addr == `WDC_ADDR_WIPER0 || addr == `WDC_ADDR_WIPER1 ||
        addr == `WDC_ADDR_TCON || addr == `WDC_ADDR_STATUS)) begin
      bad = 1'b1;
    end else if (cmd == `WDC_CMD_INC || cmd == `WDC_CMD_DEC) begin
      // Only wipers, or protection bits under high voltage, take steps.
      bad = !(addr == `WDC_ADDR_WIPER0 || addr == `WDC_ADDR_WIPER1 ||
              (hv && (addr == `WDC_ADDR_WL0 || addr == `WDC_ADDR_WL1 ||
                      addr == `WDC_ADDR_WP)));
    end
  end
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    err_nxt = err_r;
    w0_nxt = w0_r;
    w1_nxt = w1_r;
    prot_nxt = prot_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    start_nxt = 1'b0;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    case (st_r)
      wdc_pkg::WDC_IDLE: begin
        cnt_nxt = 4'h0;
        oe_nxt = 1'b0;
        if (sel_act) begin
          st_nxt = wdc_pkg::WDC_SHIFT;
        end else if (pend_v_r) begin
          // Protection write begins only once select goes inactive.
          prot_nxt = pend_r;
          start_nxt = 1'b1;
          pend_v_nxt = 1'b0;
        end
      end
      wdc_pkg::WDC_SHIFT: begin
        if (!sel_act) begin
          st_nxt = wdc_pkg::WDC_IDLE;
        end else if (rise) begin
          sh_nxt = shin;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 == `WDC_BITS_BYTE) begin
            // One byte completes a step command; the next byte starts fresh.
            cnt_nxt = 4'h0;
            if (cmd_b == `WDC_CMD_DEC || cmd_b == `WDC_CMD_INC) begin
              if (addr_b == `WDC_ADDR_WIPER0 || addr_b == `WDC_ADDR_WIPER1) begin
                // Step wiper at eighth clock, saturating and skipping above full.
                if (addr_b == `WDC_ADDR_WIPER0) begin
                  if (cmd_b == `WDC_CMD_DEC && w0_r <= full && w0_r != `WDC_ZERO) begin
                    w0_nxt = w0_r - 9'h001;
                  end else if (cmd_b == `WDC_CMD_INC && w0_r < full) begin
                    w0_nxt = w0_r + 9'h001;
                  end
                end else if (cmd_b == `WDC_CMD_DEC && w1_r <= full && w1_r != `WDC_ZERO) begin
                  w1_nxt = w1_r - 9'h001;
                end else if (cmd_b == `WDC_CMD_INC && w1_r < full) begin
                  w1_nxt = w1_r + 9'h001;
                end
              end else begin
                // Decrement sets a protection bit, increment clears it.
                // Several such commands in one select period build on each other.
                pend_nxt = pend_v_r ? pend_r : prot_r;
                if (addr_b == `WDC_ADDR_WL0) pend_nxt.wiper0_lock = (cmd_b == `WDC_CMD_DEC);
                if (addr_b == `WDC_ADDR_WL1) pend_nxt.wiper1_lock = (cmd_b == `WDC_CMD_DEC);
                if (addr_b == `WDC_ADDR_WP) pend_nxt.write_protect = (cmd_b == `WDC_CMD_DEC);
                pend_v_nxt = 1'b1;
              end
            end
          end
        end else if (fall && cnt_r == `WDC_BITS_DECODE) begin
          // The error flag leaves during clock seven; high means no error.
          oe_nxt = 1'b1;
          sdo_nxt = ~bad;
          if (bad) begin
            err_nxt = 1'b1;
            st_nxt = wdc_pkg::WDC_ERROR;
          end
        end
      end
      default: begin
        // Output held low and commands ignored until deselect.
        sdo_nxt = 1'b0;
        oe_nxt = 1'b1;
        if (!sel_act) begin
          st_nxt = wdc_pkg::WDC_IDLE;
          err_nxt = 1'b0;
          oe_nxt = 1'b0;
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r <= wdc_pkg::WDC_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      err_r <= 1'b0;
      w0_r <= `WDC_WIPER_RST;
      w1_r <= `WDC_WIPER_RST;
      prot_r <= '0;
      pend_r <= '0;
      pend_v_r <= 1'b0;
      start_r <= 1'b0;
      sdo_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      err_r <= err_nxt;
      w0_r <= w0_nxt;
      w1_r <= w1_nxt;
      prot_r <= prot_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      start_r <= start_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
    end
  end
  assign sdo_o = sdo_r;
  assign sdo_oe_o = oe_r;
  assign command_error_flag_o = err_r;
  assign wiper0_o = w0_r;
  assign wiper1_o = w1_r;
  assign prot_o = prot_r;
  assign nvm_start_o = start_r;
  // ************************************************************
  // Checks
  // ************************************************************
  a_err_holds_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (st_r == wdc_pkg::WDC_ERROR && sel_act) |=> (sdo_o == 1'b0))
    else $error("output not low after error");
  a_err_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (err_r && !sel_act) |=> ##1 !err_r)
    else $error("error flag not cleared on deselect");
  a_dec_one: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (w0_r != $past(w0_r) && $past(sel_act)) |-> (w0_r == $past(w0_r) - 9'h001 ||
     w0_r == $past(w0_r) + 9'h001))
    else $error("wiper moved by more than one");
  a_no_wrap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ($past(w0_r) == `WDC_ZERO) |-> (w0_r != 9'h1FF))
    else $error("wiper wrapped below zero");
  a_above_full: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ($past(w1_r) > full) |-> (w1_r == $past(w1_r)))
    else $error("wiper above full scale changed");
  a_start_deselect: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    nvm_start_o |-> $past(!sel_act, 2))
    else $error("write started while selected");
  a_move_eighth: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (w0_r != $past(w0_r)) |-> ($past(cnt_r) == 4'h7 && $past(rise)))
    else $error("wiper moved off the eighth clock");
  a_err_oe: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(err_r) |-> (sdo_oe_o && !sdo_o))
    else $error("error flag not driven");
endmodule

// File: bench/wdc_host_model.sv
// Serial host model that frames commands for the decrement interpreter.
// Assumes the bench resolves the serial output wire with its pull-up.
`timescale 1ns/1ps
module wdc_host_model (
  output logic sel_n_o,
  output logic hv_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_line_i
);
  // ****************
  // Host framing
  // ****************
  initial begin
    sel_n_o = 1'b1;
    hv_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Select stays active across every byte of a string.
  task automatic sel(input logic hv);
    sel_n_o <= 1'b0;
    hv_o <= hv;
    #200;
  endtask
  // Eight clocks, MSB first, and the clock then stands still.
  task automatic xfer(input logic [7:0] b, output logic f);
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= b[i];
      #62.5;
      if (i == 1) f = sdo_line_i;
      sck_o <= 1'b1;
      #62.5;
      sck_o <= 1'b0;
    end
  endtask
  // Prompt deselect; the data line flips so a stale bit is never read as live.
  task automatic desel();
    #200;
    sel_n_o <= 1'b1;
    hv_o <= 1'b0;
    sdi_o <= ~sdi_o;
    #300;
  endtask
endmodule

// File: bench/wdc_decrement_test.sv
// Self-checking bench comparing the interpreter with an integer model.
// Assumes the host model file and a pulled-up serial output line.
`timescale 1ns/1ps
`include "wdc_defs.svh"
module wdc_decrement_test;
  // ****************
  // Bench and model
  // ****************
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic nvm_i = 1'b0;
  wire logic sel_n, hv, sck, sdi;
  logic sdo, oe, err, start;
  logic [8:0] w0, w1;
  wdc_pkg::wdc_prot_s prot;
  int fails = 0, comparisons = 0, starts = 0, exp_starts = 0;
  int w[2] = '{128, 128};
  logic [2:0] pm = 3'h0, pv = 3'h0, pp = 3'h0;
  logic err_m = 1'b0, hv_m = 1'b0;
  wire logic line = oe ? sdo : 1'b1;
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (start === 1'b1) starts++;
  wdc_host_model host_u (.sel_n_o(sel_n), .hv_o(hv), .sck_o(sck), .sdi_o(sdi),
    .sdo_line_i(line));
  wdc_decrement dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sel_n_i(sel_n),
    .high_voltage_select_level_i(hv), .sck_i(sck), .sdi_i(sdi), .nvm_write_active_i(nvm_i),
    .sdo_o(sdo), .sdo_oe_o(oe), .command_error_flag_o(err), .wiper0_o(w0), .wiper1_o(w1),
    .prot_o(prot), .nvm_start_o(start));
  task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic frame_open(input logic h);
    host_u.sel(h);
    hv_m = h;
  endtask
  // Protection changes land only at deselect, with one start pulse.
  task automatic frame_close();
    host_u.desel();
    repeat (4) @(posedge sys_clk_i);
    if (pp != 3'h0) exp_starts++;
    pm = (pm & ~pp) | (pv & pp);
    pp = 3'h0;
    err_m = 1'b0;
    check_val({6'h0, prot}, {6'h0, pm});
    check_val(starts[8:0], exp_starts[8:0]);
    check_flag(err, 1'b0);
    check_flag(oe, 1'b0);
  endtask
  task automatic cmd(input int a, input logic [1:0] c);
    logic f, ok;
    int k;
    ok = !err_m && ((a < 2 && (c == `WDC_CMD_DEC || c == `WDC_CMD_INC)) ||
      (hv_m && !nvm_i && (a == 2 || a == 3 || a == 15)));
    host_u.xfer({a[3:0], c, 2'($urandom)}, f);
    if (!ok) err_m = 1'b1;
    check_flag(f, !err_m);
    check_flag(oe, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    k = (a == 2) ? 2 : (a == 3) ? 1 : 0;
    if (ok && a < 2) begin
      if (c == `WDC_CMD_DEC && w[a] > 0 && w[a] <= `WDC_FULL_8BIT) w[a]--;
      if (c == `WDC_CMD_INC && w[a] < `WDC_FULL_8BIT) w[a]++;
    end else if (ok) begin
      pp[k] = 1'b1;
      pv[k] = (c == `WDC_CMD_DEC);
    end
    check_val(w0, w[0][8:0]);
    check_val(w1, w[1][8:0]);
    check_flag(err, err_m);
  endtask
  initial begin
    void'($urandom(32'hA00E));
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    check_val(w0, `WDC_WIPER_RST);
    check_val(w1, `WDC_WIPER_RST);
    frame_open(1'b0);
    for (int i = 0; i < 140; i++) begin
      cmd(1, `WDC_CMD_DEC);
      cmd(0, `WDC_CMD_INC);
    end
    cmd(0, `WDC_CMD_DEC);
    frame_close();
    $display("test saturation done");
    frame_open(1'b0);
    for (int i = 0; i < 24; i++) cmd($urandom % 2, 2'($urandom % 2 + 1));
    frame_close();
    $display("test random string done");
    for (int a = 2; a < 16; a++) begin
      frame_open(1'b0);
      cmd(a, `WDC_CMD_DEC);
      cmd(0, `WDC_CMD_DEC);
      frame_close();
    end
    $display("test invalid address done");
    for (int j = 0; j < 6; j++) begin
      frame_open(1'b1);
      cmd(j % 3 == 2 ? 15 : 2 + j % 3, j < 3 ? `WDC_CMD_DEC : `WDC_CMD_INC);
      frame_close();
    end
    @(posedge sys_clk_i);
    nvm_i <= 1'b1;
    frame_open(1'b1);
    cmd(0, `WDC_CMD_DEC);
    cmd(2, `WDC_CMD_DEC);
    frame_close();
    @(posedge sys_clk_i);
    nvm_i <= 1'b0;
    $display("test protection done");
    // A reset in mid-run must bring the wipers, protection bits, output enable and error flag back to their idle values.
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    w = '{`WDC_WIPER_RST, `WDC_WIPER_RST};
    pm = 3'h0;
    @(posedge sys_clk_i);
    check_val(w0, w[0][8:0]);
    check_val(w1, w[1][8:0]);
    check_val({6'h0, prot}, {6'h0, pm});
    check_flag(oe, 1'b0);
    check_flag(err, 1'b0);
    frame_open(1'b0);
    cmd(0, `WDC_CMD_DEC);
    cmd(1, `WDC_CMD_INC);
    frame_close();
    $display("test reset done");
    final_report();
  end
  // The tests need well under a millisecond.
  initial begin
    #1000000;
    fails++;
    final_report();
  end
endmodule
